//--- cfs_top.sv
// Fault supervision and output voltage target selection for the charger.
`timescale 1ns/10ps

// Summary of operation
// - Floating select pin sets 5.1 V target.
// - Low select pin sets 9.1 V target.
// - High select pin keeps last target.
// - Start with high pin gives 5 V.
// - Data-line 5/9 V requests act; 12 V ignored.
// - Input over-voltage disables the converter.
// - Restart 40 ms after input over-voltage clears.
// - Output over-voltage stops switching until clear.
// - Discharge on output over-voltage or downward target change.
// - Target change completes within 100 ms.
// - Under-voltage over 10 us enters hiccup.
// - Hiccup holds converter off, then restarts.
// - Thermal shutdown above 160, release below 130.
// - Switching cycle runs at 125 kHz.
// - Peak current limit ends high-side conduction.
// - Under-voltage ignored 3.5 ms after startup.
module cfs_top
  import cfs_pkg::*;
#(
  parameter int INOV_WAIT = INOV_RESTART_CYC,
  parameter int BLANK_WAIT = UV_BLANK_CYC,
  parameter int HICCUP_WAIT = HICCUP_CYC,
  parameter int TRANS_WAIT = TRANS_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_vsel_lo,
  input wire logic i_vsel_hi,
  input wire logic i_dl_req_valid,
  input wire logic [1:0] i_dl_req_code,
  input wire logic i_in_ov,
  input wire logic i_out_ov,
  input wire logic i_out_uv,
  input wire logic i_temp_over,
  input wire logic i_temp_under,
  input wire logic i_peak_lim,
  input wire logic [DUTY_W-1:0] i_duty,
  output logic o_conv_en,
  output logic o_hs_gate,
  output logic o_target_9v,
  output logic o_discharge,
  output logic o_hiccup,
  output logic o_transition
);

  if (INOV_WAIT < 1 || BLANK_WAIT < 1 || HICCUP_WAIT < 1 ||
      TRANS_WAIT < 1) begin : g_chk
    $error("cfs_top: wait counts must be at least one cycle");
  end

  localparam int IW = $clog2(INOV_WAIT + 1);
  localparam int BW = $clog2(BLANK_WAIT + 1);
  localparam int HW = $clog2(HICCUP_WAIT + 1);
  localparam int TW = $clog2(TRANS_WAIT + 1);
  localparam int UW = $clog2(UV_DEGLITCH_CYC + 1);

  typedef struct packed {
    logic vlo1;
    logic vlo2;
    logic vhi1;
    logic vhi2;
    logic inov1;
    logic inov2;
    logic oov1;
    logic oov2;
    logic uv1;
    logic uv2;
    logic thot1;
    logic thot2;
    logic tcool1;
    logic tcool2;
    logic peak1;
    logic peak2;
    logic [1:0] pin_last;
    logic t9;
    logic down;
    logic [TW-1:0] tcnt;
    logic trans;
    logic dis;
    logic hot;
    logic [IW-1:0] icnt;
    cfs_mode_e mode;
    logic [BW-1:0] blank;
    logic [UW-1:0] uvcnt;
    logic [HW-1:0] hcnt;
    logic en;
    logic sw;
    logic hic;
    logic ctrl_en;
    logic ack;
    logic [31:0] rdat;
  } cfs_state_s;

  cfs_state_s st;
  cfs_state_s next_st;
  logic [1:0] pin_cur;
  logic pin_new;
  logic faults_clear;
  logic bus_req;
  logic [31:0] status_w;

  assign pin_cur = st.vhi2 ? PIN_HIGH : (st.vlo2 ? PIN_LOW : PIN_FLOAT);
  assign pin_new = (pin_cur != st.pin_last);
  assign faults_clear = st.ctrl_en && !st.inov2 && (st.icnt == '0) &&
                        !st.hot;
  assign bus_req = i_wb_cyc && i_wb_stb && !st.ack;

  always_comb begin
    status_w = '0;
    status_w[ST_EN_BIT] = st.en;
    status_w[ST_SW_BIT] = st.sw;
    status_w[ST_T9_BIT] = st.t9;
    status_w[ST_DIS_BIT] = st.dis;
    status_w[ST_HIC_BIT] = st.hic;
    status_w[ST_HOT_BIT] = st.hot;
    status_w[ST_INOV_BIT] = st.inov2 || (st.icnt != '0);
    status_w[ST_OOV_BIT] = st.oov2;
    status_w[ST_TRANS_BIT] = st.trans;
  end

  always_comb begin
    next_st = st;
    // Two-stage synchronisers for the pin and comparator inputs.
    next_st.vlo1 = i_vsel_lo;
    next_st.vlo2 = st.vlo1;
    next_st.vhi1 = i_vsel_hi;
    next_st.vhi2 = st.vhi1;
    next_st.inov1 = i_in_ov;
    next_st.inov2 = st.inov1;
    next_st.oov1 = i_out_ov;
    next_st.oov2 = st.oov1;
    next_st.uv1 = i_out_uv;
    next_st.uv2 = st.uv1;
    next_st.thot1 = i_temp_over;
    next_st.thot2 = st.thot1;
    next_st.tcool1 = i_temp_under;
    next_st.tcool2 = st.tcool1;
    next_st.peak1 = i_peak_lim;
    next_st.peak2 = st.peak1;

    // Target selection; a pin change to floating or low wins over a data-line request.
    next_st.pin_last = pin_cur;
    if (pin_new && pin_cur == PIN_FLOAT) begin
      next_st.t9 = 1'b0;
    end else if (pin_new && pin_cur == PIN_LOW) begin
      next_st.t9 = 1'b1;
    end else if (i_dl_req_valid) begin
      case (i_dl_req_code)
        DL_5V: next_st.t9 = 1'b0;
        DL_9V: next_st.t9 = 1'b1;
        default: next_st.t9 = st.t9;
      endcase
    end else begin
      next_st.t9 = st.t9;
    end

    // Transition window and downward discharge.
    if (next_st.t9 != st.t9) begin
      next_st.tcnt = TW'(TRANS_WAIT);
      next_st.down = st.t9;
    end else if (st.tcnt != '0) begin
      next_st.tcnt = st.tcnt - TW'(1);
    end else begin
      next_st.down = 1'b0;
    end
    next_st.trans = (next_st.tcnt != '0);
    next_st.dis = st.oov2 || next_st.down;

    // Thermal shutdown with hysteresis; the hot flag wins.
    if (st.thot2) begin
      next_st.hot = 1'b1;
    end else if (st.tcool2) begin
      next_st.hot = 1'b0;
    end

    // Input over-voltage hold and restart wait.
    if (st.inov2) begin
      next_st.icnt = IW'(INOV_WAIT);
    end else if (st.icnt != '0) begin
      next_st.icnt = st.icnt - IW'(1);
    end

    case (st.mode)
      CFS_OFF: begin
        if (faults_clear) begin
          next_st.mode = CFS_RUN;
          next_st.blank = BW'(BLANK_WAIT);
          next_st.uvcnt = '0;
        end
      end
      CFS_RUN: begin
        if (!faults_clear) begin
          next_st.mode = CFS_OFF;
        end else if (st.blank != '0) begin
          next_st.blank = st.blank - BW'(1);
          next_st.uvcnt = '0;
        end else if (st.uv2) begin
          if (st.uvcnt == UW'(UV_DEGLITCH_CYC)) begin
            next_st.mode = CFS_HICCUP;
            next_st.hcnt = HW'(HICCUP_WAIT);
          end else begin
            next_st.uvcnt = st.uvcnt + UW'(1);
          end
        end else begin
          next_st.uvcnt = '0;
        end
      end
      CFS_HICCUP: begin
        if (st.hcnt != '0) begin
          next_st.hcnt = st.hcnt - HW'(1);
        end else begin
          next_st.mode = CFS_OFF;
        end
      end
      default: begin
        next_st.mode = CFS_OFF;
      end
    endcase
    next_st.en = (next_st.mode == CFS_RUN);
    next_st.sw = next_st.en && !st.oov2;
    next_st.hic = (next_st.mode == CFS_HICCUP);

    // Wishbone slave, one-cycle registered answer.
    next_st.ack = bus_req;
    if (bus_req) begin
      if (i_wb_we && i_wb_adr == ADDR_CTRL && i_wb_sel[0]) begin
        next_st.ctrl_en = i_wb_dat[CTRL_EN_BIT];
      end
      if (i_wb_adr == ADDR_CTRL) begin
        next_st.rdat = '0;
        next_st.rdat[CTRL_EN_BIT] = st.ctrl_en;
      end else if (i_wb_adr == ADDR_STATUS) begin
        next_st.rdat = status_w;
      end else begin
        next_st.rdat = '0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st <= '0;
      st.ctrl_en <= CTRL_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  cfs_pwm #(
    .PERIOD(SW_PERIOD_CYC),
    .MAX_ON(MAX_ON_CYC),
    .PW(DUTY_W)
  ) u_pwm (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_run(st.sw),
    .i_duty(i_duty),
    .i_peak(st.peak2),
    .o_gate(o_hs_gate)
  );

  assign o_wb_dat = st.rdat;
  assign o_wb_ack = st.ack;
  assign o_conv_en = st.en;
  assign o_target_9v = st.t9;
  assign o_discharge = st.dis;
  assign o_hiccup = st.hic;
  assign o_transition = st.trans;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_inov_fall;
    $fell(st.inov2);
  endsequence

  sequence s_hic_enter;
    $rose(o_hiccup);
  endsequence

  a_float_5v: assert property (
    (pin_new && pin_cur == PIN_FLOAT) |=> !o_target_9v)
    else $error("floating pin did not select 5 V");
  a_low_9v: assert property (
    (pin_new && pin_cur == PIN_LOW) |=> o_target_9v)
    else $error("low pin did not select 9 V");
  a_high_keep: assert property (
    (pin_cur == PIN_HIGH && !i_dl_req_valid) |=> $stable(o_target_9v))
    else $error("high pin changed the target");
  a_dl_12v: assert property (
    (!pin_new && i_dl_req_valid && i_dl_req_code == DL_12V)
    |=> $stable(o_target_9v))
    else $error("12 V request changed the target");
  a_inov_off: assert property (st.inov2 |=> !o_conv_en)
    else $error("converter on during input over-voltage");
  a_inov_wait: assert property (s_inov_fall |=> (!o_conv_en) [*8])
    else $error("converter restarted without the wait");
  a_oov_stop: assert property (st.oov2 |-> ##2 !o_hs_gate)
    else $error("switching during output over-voltage");
  a_oov_disch: assert property (st.oov2 |=> o_discharge)
    else $error("no discharge on output over-voltage");
  a_down_disch: assert property ($fell(o_target_9v) |-> o_discharge)
    else $error("no discharge on downward transition");
  a_trans_win: assert property ($changed(o_target_9v) |-> o_transition)
    else $error("transition window not opened");
  a_uv_hiccup: assert property (
    (st.mode == CFS_RUN && faults_clear && st.blank == '0 && st.uv2 &&
     st.uvcnt == UW'(UV_DEGLITCH_CYC)) |=> (o_hiccup && !o_conv_en))
    else $error("lasting under-voltage did not enter hiccup");
  a_hic_hold: assert property (
    s_hic_enter |-> (o_hiccup && !o_conv_en) [*8])
    else $error("hiccup released too early");
  a_hot_keep: assert property ((st.hot && !st.tcool2) |=> st.hot)
    else $error("thermal shutdown released while hot");
  a_blank_uv: assert property (
    (st.mode == CFS_RUN && st.blank != '0) |=> !o_hiccup)
    else $error("hiccup entered during blanking");
  a_all_clear: assert property ($rose(o_conv_en) |-> $past(faults_clear))
    else $error("converter enabled with a fault active");

endmodule

//--- cfs_pkg.sv
// Constants shared by the charger fault and voltage select block.
package cfs_pkg;

  // Clock rate.
  localparam int CLK_KHZ = 125000;

  // Input over-voltage restart wait, 40 ms.
  localparam int INOV_RESTART_MS = 40;
  localparam int INOV_RESTART_CYC = INOV_RESTART_MS * CLK_KHZ;

  // Output under-voltage deglitch, 10 us.
  localparam int UV_DEGLITCH_US = 10;
  localparam int UV_DEGLITCH_CYC = (UV_DEGLITCH_US * CLK_KHZ + 999) / 1000;

  // Under-voltage blanking after startup, 3.5 ms.
  localparam int UV_BLANK_US = 3500;
  localparam int UV_BLANK_CYC = (UV_BLANK_US * CLK_KHZ + 999) / 1000;

  // Hiccup waiting period, 4.13 s.
  localparam int HICCUP_MS = 4130;
  localparam int HICCUP_CYC = HICCUP_MS * CLK_KHZ;

  // Longest voltage target transition, 100 ms.
  localparam int TRANS_MS = 100;
  localparam int TRANS_CYC = TRANS_MS * CLK_KHZ;

  // Switching cycle, 125 kHz, 99 percent longest duty.
  localparam int SW_KHZ = 125;
  localparam int SW_PERIOD_CYC = CLK_KHZ / SW_KHZ;
  localparam int MAX_DUTY_PCT = 99;
  localparam int MAX_ON_CYC = SW_PERIOD_CYC * MAX_DUTY_PCT / 100;
  localparam int DUTY_W = $clog2(SW_PERIOD_CYC);

  // Register map.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int ST_EN_BIT = 0;
  localparam int ST_SW_BIT = 1;
  localparam int ST_T9_BIT = 2;
  localparam int ST_DIS_BIT = 3;
  localparam int ST_HIC_BIT = 4;
  localparam int ST_HOT_BIT = 5;
  localparam int ST_INOV_BIT = 6;
  localparam int ST_OOV_BIT = 7;
  localparam int ST_TRANS_BIT = 8;

  // Decoded state of the voltage select pin.
  localparam logic [1:0] PIN_FLOAT = 2'h0;
  localparam logic [1:0] PIN_LOW = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  // Data-line voltage request codes.
  localparam logic [1:0] DL_5V = 2'h0;
  localparam logic [1:0] DL_9V = 2'h1;
  localparam logic [1:0] DL_12V = 2'h2;

  typedef enum logic [1:0] {
    CFS_OFF,
    CFS_RUN,
    CFS_HICCUP
  } cfs_mode_e;

endpackage

//--- cfs_pwm.sv
// Switching cycle timer with peak current cut-off.
`timescale 1ns/10ps
module cfs_pwm
  import cfs_pkg::*;
#(
  parameter int PERIOD = SW_PERIOD_CYC,
  parameter int MAX_ON = MAX_ON_CYC,
  parameter int PW = $clog2(PERIOD)
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic [PW-1:0] i_duty,
  input wire logic i_peak,
  output logic o_gate
);

  if (PERIOD < 2 || MAX_ON >= PERIOD || MAX_ON < 1) begin : g_chk
    $error("cfs_pwm: period or on-time limit not usable");
  end

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic gate;
  } cfs_pwm_s;

  cfs_pwm_s st;
  cfs_pwm_s next_st;
  logic [PW-1:0] lim;
  logic [PW-1:0] ncnt;

  assign lim = (i_duty > PW'(MAX_ON)) ? PW'(MAX_ON) : i_duty;
  assign ncnt = (st.cnt == PW'(PERIOD - 1)) ? '0 : st.cnt + PW'(1);

  always_comb begin
    next_st = st;
    if (!i_run) begin
      next_st.cnt = '0;
      next_st.gate = 1'b0;
    end else begin
      next_st.cnt = ncnt;
      if (ncnt == '0) begin
        next_st.gate = (lim != '0) && !i_peak;
      end else begin
        next_st.gate = st.gate && !i_peak && (ncnt < lim);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_gate = st.gate;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_peak_cut: assert property (i_peak |=> !o_gate)
    else $error("gate stayed on after peak limit");
  a_period_wrap: assert property (
    (st.cnt == PW'(PERIOD - 1) && i_run) |=> (st.cnt == '0))
    else $error("switching period did not wrap");

endmodule

//--- cfs_far_end.sv
// Far-side model: power-delivery controller and handset data lines.
`timescale 1ns/10ps
module cfs_far_end
  import cfs_pkg::*;
(
  input wire logic i_mclk,
  output logic o_vsel_lo,
  output logic o_vsel_hi,
  output logic o_dl_req_valid,
  output logic [1:0] o_dl_req_code
);
  // The pin starts pulled high, so the start-up target is exercised.
  initial begin
    o_vsel_lo = 1'h0;
    o_vsel_hi = 1'h1;
    o_dl_req_valid = 1'h0;
    o_dl_req_code = 2'h3;
  end

  // Drives the select pin to floating, low or high.
  task automatic set_pin(input logic [1:0] st);
    @(posedge i_mclk);
    o_vsel_lo <= (st == PIN_LOW);
    o_vsel_hi <= (st == PIN_HIGH);
  endtask

  // Sends one request pulse; the code lines carry junk when idle.
  task automatic dl_request(input logic [1:0] code);
    @(posedge i_mclk);
    o_dl_req_valid <= 1'h1;
    o_dl_req_code <= code;
    @(posedge i_mclk);
    o_dl_req_valid <= 1'h0;
    o_dl_req_code <= ~code;
  endtask
endmodule

//--- tb.sv
// Self-checking testbench for the charger supervisor.
`timescale 1ns/10ps
module tb
  import cfs_pkg::*;
;
  localparam int EN = 0;
  localparam int GATE = 1;
  localparam int T9 = 2;
  localparam int DIS = 3;
  localparam int HIC = 4;
  localparam int TRANS = 5;
  logic i_mclk = 1'h0;
  logic i_rst_b = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000;
  logic in_ov = 1'h0;
  logic out_ov = 1'h0;
  logic out_uv = 1'h0;
  logic t_over = 1'h0;
  logic t_under = 1'h0;
  logic peak = 1'h0;
  logic [DUTY_W-1:0] duty = '0;
  logic [31:0] rdat;
  logic ack;
  wire [5:0] outs;
  logic vlo;
  logic vhi;
  logic dlv;
  logic [1:0] dlc;
  logic [31:0] q;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  logic [1:0] codes [4] = '{DL_9V, DL_12V, 2'h3, DL_5V};
  logic exp9 [4] = '{1'h1, 1'h1, 1'h1, 1'h0};

  initial begin
    forever #4 i_mclk = ~i_mclk;
  end

  cfs_far_end far_u (.i_mclk(i_mclk), .o_vsel_lo(vlo), .o_vsel_hi(vhi),
    .o_dl_req_valid(dlv), .o_dl_req_code(dlc));

  cfs_top #(.INOV_WAIT(50), .BLANK_WAIT(20), .HICCUP_WAIT(40),
    .TRANS_WAIT(30)) dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_vsel_lo(vlo), .i_vsel_hi(vhi), .i_dl_req_valid(dlv),
    .i_dl_req_code(dlc), .i_in_ov(in_ov), .i_out_ov(out_ov),
    .i_out_uv(out_uv), .i_temp_over(t_over), .i_temp_under(t_under),
    .i_peak_lim(peak), .i_duty(duty), .o_conv_en(outs[EN]),
    .o_hs_gate(outs[GATE]), .o_target_9v(outs[T9]),
    .o_discharge(outs[DIS]), .o_hiccup(outs[HIC]),
    .o_transition(outs[TRANS]));

  task automatic report_and_stop;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, got);
    num_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, got);
    end
  endtask

  // One classic cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_mclk);
      k++;
    end while (ack !== 1'h1 && k < 20);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (k >= 20) begin
      chk("wb_ack", 1, 0);
      report_and_stop();
    end
  endtask

  task automatic wait_out(input int i, input logic v, input int lim,
    input string nm);
    int k;
    for (k = 0; k < lim && outs[i] !== v; k++) @(posedge i_mclk);
    chk(nm, v, outs[i]);
  endtask

  task automatic hold(input int i, input logic v, input int cnt,
    input string nm);
    logic bad;
    bad = 1'h0;
    repeat (cnt) begin
      @(posedge i_mclk);
      if (outs[i] !== v) bad = 1'h1;
    end
    chk(nm, 0, bad);
  endtask

  initial begin
    repeat (100000) @(posedge i_mclk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'h1;
    repeat (5) @(posedge i_mclk);
    chk("target_at_start", 0, outs[T9]);
    wb(1'h0, ADDR_CTRL, 0);
    chk("ctrl_reset", 32'h0000_0001, q);
    wb(1'h0, ADDR_STATUS, 0);
    chk("status_en", 1, q[ST_EN_BIT]);
    wb(1'h0, 8'h08, 0);
    chk("unmapped", 0, q);
    wb(1'h1, ADDR_CTRL, 0);
    wait_out(EN, 0, 5, "ctrl_off");
    wb(1'h1, ADDR_CTRL, 32'h0000_0001);
    wait_out(EN, 1, 5, "ctrl_on");
    far_u.set_pin(PIN_LOW);
    wait_out(T9, 1, 6, "pin_low");
    chk("trans_up", 1, outs[TRANS]);
    far_u.set_pin(PIN_HIGH);
    hold(T9, 1, 10, "pin_high_keep");
    far_u.set_pin(PIN_FLOAT);
    wait_out(T9, 0, 6, "pin_float");
    chk("dis_down", 1, outs[DIS]);
    wait_out(TRANS, 0, 36, "trans_end");
    far_u.set_pin(PIN_HIGH);
    for (n = 0; n < 4; n++) begin
      far_u.dl_request(codes[n]);
      repeat (3) @(posedge i_mclk);
      chk("dl_target", exp9[n], outs[T9]);
    end
    duty <= 10'h1f4;
    wait_out(GATE, 1, 1100, "gate_on");
    for (n = 0; n < 1100 && outs[GATE] === 1'h1; n++) @(posedge i_mclk);
    chk("on_time", 500, n);
    for (; n < 1100 && outs[GATE] !== 1'h1; n++) @(posedge i_mclk);
    chk("period", SW_PERIOD_CYC, n);
    peak <= 1'h1;
    wait_out(GATE, 0, 5, "peak_cut");
    peak <= 1'h0;
    hold(GATE, 0, 400, "peak_rest");
    out_ov <= 1'h1;
    wait_out(DIS, 1, 4, "ov_dis");
    hold(GATE, 0, 1200, "ov_stop");
    out_ov <= 1'h0;
    wait_out(GATE, 1, 1100, "ov_resume");
    in_ov <= 1'h1;
    wait_out(EN, 0, 4, "inov_off");
    in_ov <= 1'h0;
    hold(EN, 0, 40, "inov_wait");
    wait_out(EN, 1, 20, "inov_back");
    t_over <= 1'h1;
    in_ov <= 1'h1;
    wait_out(EN, 0, 4, "hot_off");
    t_over <= 1'h0;
    in_ov <= 1'h0;
    hold(EN, 0, 80, "hot_hold");
    t_under <= 1'h1;
    wait_out(EN, 1, 10, "hot_back");
    t_under <= 1'h0;
    out_uv <= 1'h1;
    hold(HIC, 0, 1200, "uv_deglitch");
    wait_out(HIC, 1, 100, "hiccup");
    chk("hic_off", 0, outs[EN]);
    out_uv <= 1'h0;
    hold(EN, 0, 38, "hic_wait");
    wait_out(EN, 1, 15, "hic_restart");
    report_and_stop();
  end
endmodule
